// File: hdl/fsw_pkg.sv
// package: constants, types and helpers of the fieldbus slave watchdog block
// Overview of operation
// RULE1 - silent local interface past timeout trips watchdog
// RULE2 - shared tick multiplier, separate count per watchdog
// RULE3 - master writes settings only with manual setting
// RULE4 - tick is multiplier plus two base periods
// RULE5 - default multiplier 2498 gives 100 us tick
// RULE6 - process-data count defaults to 1000 ticks
// RULE7 - count 0..65535, multiplier 1..65535 accepted
// RULE8 - process-data silence with outputs set clears outputs
// RULE9 - count zero disables the process-data watchdog
// RULE10 - five states, full-exchange is the regular one
// RULE11 - init after reset refuses mailbox and process data
// RULE12 - master sets up channel units 0, 1 in init
// RULE13 - init to configuration needs valid mailbox setup
// RULE14 - configuration allows mailbox, blocks process data
// RULE15 - master sets up process-data units in configuration
// RULE16 - inputs-only entry checks setup, then copies inputs
// RULE17 - inputs-only: traffic allowed, outputs held safe
// RULE18 - master writes valid outputs before full-exchange
// RULE19 - full-exchange copies output data to outputs
// RULE20 - firmware-load entered only from init
// RULE21 - firmware-load: file-transfer mailbox only
// RULE22 - only process-data access restarts its watchdog
// RULE23 - tripped watchdog clears outputs, keeps state; here only the process-data watchdog clears them, not the application one
// RULE24 - illegal transition refused, error flag set
// RULE25 - expiry flag held until next monitored access
`default_nettype none
package fsw_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_REQ     = 8'h04;
   localparam logic [7:0] ADDR_STATUS  = 8'h08;
   localparam logic [7:0] ADDR_MULT    = 8'h0c;
   localparam logic [7:0] ADDR_PD_CNT  = 8'h10;
   localparam logic [7:0] ADDR_APP_CNT = 8'h14;
   localparam logic [7:0] ADDR_OUT     = 8'h18;
   localparam logic [7:0] ADDR_IN      = 8'h1c;

   // field positions
   localparam int CTRL_PD_EN  = 0;
   localparam int CTRL_APP_EN = 1;
   localparam int ST_ERR      = 4;
   localparam int ST_PD_EXP   = 5;
   localparam int ST_APP_EXP  = 6;
   localparam int ST_OUT_ACT  = 7;

   // reset values
   localparam logic        RST_PD_EN    = 1'b1;
   localparam logic        RST_APP_EN   = 1'b0;
   localparam logic [15:0] RST_MULT     = 16'h09c2;
   localparam logic [15:0] RST_PD_CNT   = 16'h03e8;
   localparam logic [15:0] RST_APP_CNT  = 16'h03e8;

   // timing: tick = (multiplier + 2) base periods
   localparam int BASE_PERIOD_NS = 40;
   localparam int SYS_PERIOD_NS  = 50;
   localparam int TIME_UNIT_NS   = 10;
   localparam int BASE_UNITS     = BASE_PERIOD_NS / TIME_UNIT_NS;
   localparam int SYS_UNITS      = SYS_PERIOD_NS / TIME_UNIT_NS;
   localparam int TICK_BASE_ADD  = 2;
   localparam int IMG_W          = 32;

   typedef enum logic [3:0] {
      SS_INIT   = 4'h1,
      SS_CONF   = 4'h2,
      SS_BOOT   = 4'h3,
      SS_INPUTS = 4'h4,
      SS_FULL   = 4'h8
   } fsw_ss_t;

   typedef struct packed {
      fsw_ss_t          ss;
      logic             err;
      logic             pd_en;
      logic             app_en;
      logic [15:0]      mult;
      logic [15:0]      pd_cnt;
      logic [15:0]      app_cnt;
      logic [IMG_W-1:0] out_img;
      logic [IMG_W-1:0] in_img;
      logic [IMG_W-1:0] phys_out;
      logic [31:0]      rdata;
      logic [19:0]      acc;
      logic             tick;
      logic [19:0]      gap;
      logic             gok;
      logic             dp_vld;
      logic             dp_wr;
      logic [7:0]       dp_addr;
   } fsw_state_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic        expired;
   } fsw_wd_t;

   function automatic logic [19:0] fsw_tick_thr(input logic [15:0] mult);
      return (20'(mult) + 20'(TICK_BASE_ADD)) * 20'(BASE_UNITS);
   endfunction

   function automatic logic fsw_trans_ok(input fsw_ss_t cur, input fsw_ss_t req);
      logic ok;
      ok = 1'b0;
      case (cur)
         SS_INIT:   ok = (req == SS_CONF) || (req == SS_BOOT);
         SS_CONF:   ok = (req == SS_INIT) || (req == SS_INPUTS);
         SS_INPUTS: ok = (req == SS_INIT) || (req == SS_CONF) || (req == SS_FULL);
         SS_FULL:   ok = (req == SS_INIT) || (req == SS_CONF) || (req == SS_INPUTS);
         SS_BOOT:   ok = (req == SS_INIT);
         default:   ok = 1'b0;
      endcase
      return ok;
   endfunction

   function automatic logic fsw_pd_ok(input fsw_ss_t ss);
      return (ss == SS_INPUTS) || (ss == SS_FULL);
   endfunction

endpackage
`default_nettype wire

// File: hdl/fsw_wdog.sv
// single watchdog timer counting shared ticks against its own limit
`timescale 1ns/1ps
`default_nettype none
module fsw_wdog (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   // tick and traffic
   input  wire logic        tick_i,
   input  wire logic        restart_i,
   // settings
   input  wire logic        enable_i,
   input  wire logic [15:0] limit_i,
   // result
   output logic             expired_o
);

   fsw_pkg::fsw_wd_t st;
   fsw_pkg::fsw_wd_t next_st;

   always_comb begin
      next_st = st;
      // traffic in the tripping cycle wins: the line was not silent
      if (restart_i || !enable_i || (limit_i == 16'h0000)) begin // RULE9 RULE22
         next_st.cnt     = 16'h0000;
         next_st.expired = 1'b0;
      end else if (tick_i && !st.expired) begin // RULE2
         next_st.cnt     = st.cnt + 16'h0001;
         next_st.expired = (next_st.cnt == limit_i); // RULE1 RULE8
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign expired_o = st.expired;

   wd_off_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE9
      (limit_i == 16'h0000 || !enable_i) |=> !expired_o)
      else $error("watchdog tripped while disabled");

   wd_restart_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE22
      restart_i |=> (!expired_o && st.cnt == 16'h0000))
      else $error("traffic did not restart watchdog");

   wd_sticky_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE25
      (expired_o && !restart_i && enable_i && limit_i != 16'h0000) |=> expired_o)
      else $error("expiry flag dropped without traffic");

   wd_trip_count_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE2
      $rose(expired_o) |-> ($past(tick_i) && st.cnt == $past(limit_i)))
      else $error("watchdog tripped at wrong tick count");

endmodule
`default_nettype wire

// File: hdl/fsw_top.sv
// slave state machine, tick prescaler, two watchdogs and ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
module fsw_top (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rstn_i,
   // ahb-lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   // mailbox gate
   input  wire logic        mbx_req_i,
   input  wire logic        mbx_file_i,
   output logic             mbx_accept_o,
   output logic             mbx_reject_o,
   // setup checks
   input  wire logic        mbx_cfg_ok_i,
   input  wire logic        pd_cfg_ok_i,
   input  wire logic        clk_cfg_ok_i,
   // local application interface
   input  wire logic        app_access_i,
   input  wire logic [31:0] app_inputs_i,
   // process image and state
   output logic [31:0]      phys_out_o,
   output logic [3:0]       state_o,
   output logic             pd_wd_expired_o,
   output logic             app_wd_expired_o
);

   fsw_pkg::fsw_state_t st;
   fsw_pkg::fsw_state_t next_st;

   logic               pd_exp;
   logic               app_exp;
   logic               pd_access;
   logic               addr_vld;
   logic               wr_vld;
   logic               req_wr;
   fsw_pkg::fsw_ss_t   req_ss;
   logic [19:0]        acc_sum;
   logic [19:0]        tick_thr;
   logic [31:0]        status_word;

   assign tick_thr = fsw_pkg::fsw_tick_thr(st.mult); // RULE4
   assign acc_sum  = st.acc + 20'(fsw_pkg::SYS_UNITS);

   // only full-word transfers are served, single or burst beats alike
   assign addr_vld = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'h2);
   assign wr_vld   = st.dp_vld && st.dp_wr;
   assign req_wr   = wr_vld && (st.dp_addr == fsw_pkg::ADDR_REQ);
   assign req_ss   = fsw_pkg::fsw_ss_t'(hwdata_i[3:0]);

   // process-data access: output write or input read while allowed
   always_comb begin
      pd_access = 1'b0;
      if (fsw_pkg::fsw_pd_ok(st.ss)) begin // RULE14 RULE21
         if (wr_vld && st.dp_addr == fsw_pkg::ADDR_OUT) begin
            pd_access = 1'b1;
         end
         if (addr_vld && !hwrite_i && haddr_i[7:0] == fsw_pkg::ADDR_IN) begin
            pd_access = 1'b1;
         end
      end
   end

   always_comb begin
      status_word              = 32'h0000_0000;
      status_word[3:0]         = st.ss;
      status_word[fsw_pkg::ST_ERR]     = st.err;
      status_word[fsw_pkg::ST_PD_EXP]  = pd_exp;
      status_word[fsw_pkg::ST_APP_EXP] = app_exp;
      status_word[fsw_pkg::ST_OUT_ACT] = (st.phys_out != '0);
   end

   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;

      // fractional prescaler: 50 ns steps against 40 ns base periods
      if (acc_sum >= tick_thr) begin // RULE2 RULE4
         next_st.acc  = acc_sum - tick_thr;
         next_st.tick = 1'b1;
      end else begin
         next_st.acc = acc_sum;
      end
      next_st.gap = st.tick ? 20'h0_0001 : st.gap + 20'h0_0001;
      next_st.gok = st.tick ? 1'b1 : st.gok;

      // address phase: capture and prepare read data
      next_st.dp_vld = addr_vld;
      if (addr_vld) begin
         next_st.dp_wr   = hwrite_i;
         next_st.dp_addr = haddr_i[7:0];
         case (haddr_i[7:0])
            fsw_pkg::ADDR_CTRL: begin
               next_st.rdata = {30'h0, st.app_en, st.pd_en};
            end
            fsw_pkg::ADDR_REQ: begin
               next_st.rdata = {28'h0, st.ss};
            end
            fsw_pkg::ADDR_STATUS: begin
               next_st.rdata = status_word;
            end
            fsw_pkg::ADDR_MULT: begin
               next_st.rdata = {16'h0, st.mult};
            end
            fsw_pkg::ADDR_PD_CNT: begin
               next_st.rdata = {16'h0, st.pd_cnt};
            end
            fsw_pkg::ADDR_APP_CNT: begin
               next_st.rdata = {16'h0, st.app_cnt};
            end
            fsw_pkg::ADDR_OUT: begin
               next_st.rdata = st.out_img;
            end
            fsw_pkg::ADDR_IN: begin
               // blocked states show nothing of the inputs
               next_st.rdata = fsw_pkg::fsw_pd_ok(st.ss) ? st.in_img : 32'h0;
            end
            default: begin
               next_st.rdata = 32'h0000_0000;
            end
         endcase
      end

      // data phase: register writes
      if (wr_vld) begin
         case (st.dp_addr)
            fsw_pkg::ADDR_CTRL: begin
               next_st.pd_en  = hwdata_i[fsw_pkg::CTRL_PD_EN];
               next_st.app_en = hwdata_i[fsw_pkg::CTRL_APP_EN];
            end
            fsw_pkg::ADDR_MULT: begin
               // zero is outside the range and is dropped
               if (hwdata_i[15:0] != 16'h0000) begin // RULE7
                  next_st.mult = hwdata_i[15:0];
                  next_st.gok  = 1'b0;
                  // restart prescaler: a stale phase would fire a burst of ticks
                  next_st.acc  = 20'h0_0000;
               end
            end
            fsw_pkg::ADDR_PD_CNT: begin
               next_st.pd_cnt = hwdata_i[15:0]; // RULE7
            end
            fsw_pkg::ADDR_APP_CNT: begin
               next_st.app_cnt = hwdata_i[15:0];
            end
            fsw_pkg::ADDR_OUT: begin
               if (pd_access) begin // RULE14
                  next_st.out_img = hwdata_i;
               end
            end
            default: begin
               next_st.err = st.err;
            end
         endcase
      end

      // inputs track the application while exchange runs
      if (fsw_pkg::fsw_pd_ok(st.ss)) begin // RULE17
         next_st.in_img = app_inputs_i;
      end

      // state change requests
      if (req_wr && req_ss != st.ss) begin
         if (!fsw_pkg::fsw_trans_ok(st.ss, req_ss)) begin // RULE20 RULE24
            next_st.err = 1'b1;
         end else if (req_ss == fsw_pkg::SS_CONF && st.ss == fsw_pkg::SS_INIT
                      && !mbx_cfg_ok_i) begin // RULE13
            next_st.err = 1'b1;
         end else if (req_ss == fsw_pkg::SS_INPUTS && st.ss == fsw_pkg::SS_CONF
                      && !(pd_cfg_ok_i && clk_cfg_ok_i)) begin // RULE16
            next_st.err = 1'b1;
         end else begin
            next_st.ss  = req_ss; // RULE10
            next_st.err = 1'b0;
            if (req_ss == fsw_pkg::SS_INPUTS) begin
               next_st.in_img = app_inputs_i; // RULE16
            end
         end
      end

      // outputs only in full exchange with a quiet watchdog
      if (next_st.ss == fsw_pkg::SS_FULL && !pd_exp) begin // RULE19
         next_st.phys_out = next_st.out_img;
      end else begin
         next_st.phys_out = '0; // RULE8 RULE17 RULE23
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rstn_i) begin
         st         <= '0;
         st.ss      <= fsw_pkg::SS_INIT; // RULE11
         st.pd_en   <= fsw_pkg::RST_PD_EN;
         st.app_en  <= fsw_pkg::RST_APP_EN;
         st.mult    <= fsw_pkg::RST_MULT; // RULE5
         st.pd_cnt  <= fsw_pkg::RST_PD_CNT; // RULE6
         st.app_cnt <= fsw_pkg::RST_APP_CNT;
      end else begin
         st <= next_st;
      end
   end

   // process-data watchdog: restarted only by a granted access
   fsw_wdog u_pd_wdog (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .tick_i    (st.tick),
      .restart_i (pd_access), // RULE22
      .enable_i  (st.pd_en),
      .limit_i   (st.pd_cnt),
      .expired_o (pd_exp)
   );

   // local application watchdog
   fsw_wdog u_app_wdog (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .tick_i    (st.tick),
      .restart_i (app_access_i), // RULE1
      .enable_i  (st.app_en),
      .limit_i   (st.app_cnt),
      .expired_o (app_exp)
   );

   // mailbox gate: init refuses all, firmware-load only file transfer
   always_comb begin
      mbx_accept_o = 1'b0;
      case (st.ss)
         fsw_pkg::SS_INIT: begin
            mbx_accept_o = 1'b0; // RULE11
         end
         fsw_pkg::SS_BOOT: begin
            mbx_accept_o = mbx_req_i && mbx_file_i; // RULE21
         end
         fsw_pkg::SS_CONF,
         fsw_pkg::SS_INPUTS,
         fsw_pkg::SS_FULL: begin
            mbx_accept_o = mbx_req_i; // RULE14
         end
         default: begin
            mbx_accept_o = 1'b0;
         end
      endcase
   end
   assign mbx_reject_o = mbx_req_i && !mbx_accept_o;

   assign hreadyout_o      = 1'b1;
   assign hresp_o          = 1'b0;
   assign hrdata_o         = st.rdata;
   assign phys_out_o       = st.phys_out;
   assign state_o          = st.ss;
   assign pd_wd_expired_o  = pd_exp; // RULE25
   assign app_wd_expired_o = app_exp;

   init_mbx_block_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE11
      (st.ss == fsw_pkg::SS_INIT && mbx_req_i) |-> (mbx_reject_o && !mbx_accept_o))
      else $error("mailbox accepted in init");

   conf_pd_block_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE14
      (wr_vld && st.dp_addr == fsw_pkg::ADDR_OUT && st.ss == fsw_pkg::SS_CONF)
      |=> $stable(st.out_img))
      else $error("output image written in configuration state");

   boot_from_init_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE20
      (st.ss == fsw_pkg::SS_BOOT && $past(st.ss) != fsw_pkg::SS_BOOT)
      |-> $past(st.ss) == fsw_pkg::SS_INIT)
      else $error("firmware-load entered from other than init");

   boot_mbx_only_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE21
      (st.ss == fsw_pkg::SS_BOOT && mbx_req_i && !mbx_file_i) |-> mbx_reject_o)
      else $error("non file-transfer mailbox accepted in firmware-load");

   safe_outputs_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE17
      (st.ss != fsw_pkg::SS_FULL) |-> (phys_out_o == 32'h0))
      else $error("outputs driven outside full exchange");

   trip_clears_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE23
      $rose(pd_exp) |=> phys_out_o == 32'h0 && (st.ss == $past(st.ss) || $past(req_wr)))
      else $error("watchdog trip left outputs or changed state");

   bad_req_err_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE24
      (req_wr && req_ss != st.ss && !fsw_pkg::fsw_trans_ok(st.ss, req_ss))
      |=> (st.err && $stable(st.ss)))
      else $error("illegal transition not refused");

   inputs_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE16
      (st.ss == fsw_pkg::SS_INPUTS && $past(st.ss) == fsw_pkg::SS_CONF)
      |-> ($past(pd_cfg_ok_i) && $past(clk_cfg_ok_i) && st.in_img == $past(app_inputs_i)))
      else $error("inputs-only entered without check or input copy");

   conf_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE13
      (st.ss == fsw_pkg::SS_CONF && $past(st.ss) == fsw_pkg::SS_INIT) |-> $past(mbx_cfg_ok_i))
      else $error("configuration entered with bad mailbox setup");

   tick_period_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE4
      (st.tick && st.gok)
      |-> (20'(st.gap * 20'h5) + 20'h4 >= tick_thr && 20'(st.gap * 20'h5) <= tick_thr + 20'h4))
      else $error("watchdog tick period off");

   mult_zero_drop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE7
      (wr_vld && st.dp_addr == fsw_pkg::ADDR_MULT && hwdata_i[15:0] == 16'h0000)
      |=> $stable(st.mult))
      else $error("zero multiplier accepted");

   full_out_copy_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE19
      (st.ss == fsw_pkg::SS_FULL && !pd_exp && !wr_vld)
      |=> phys_out_o == $past(st.out_img))
      else $error("outputs do not follow output image");

   inputs_track_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE17
      fsw_pkg::fsw_pd_ok(st.ss)
      |=> st.in_img == $past(app_inputs_i))
      else $error("inputs not refreshed during exchange");

   same_req_noop_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE24
      (req_wr && req_ss == st.ss)
      |=> ($stable(st.ss) && $stable(st.err)))
      else $error("request for current state had an effect");

   tick_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE4
      st.tick |=> !st.tick)
      else $error("watchdog tick longer than one cycle");

   pd_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE11 RULE21
      (!fsw_pkg::fsw_pd_ok(st.ss) && wr_vld) |=> $stable(st.out_img))
      else $error("output image written while process data blocked");

   mbx_one_answer_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i) // RULE14
      mbx_req_i |-> (mbx_accept_o ^ mbx_reject_o))
      else $error("mailbox request without exactly one answer");

endmodule
`default_nettype wire

// File: dv/fsw_ahb_master.sv
// bus master model: single word ahb-lite transfers toward the slave registers
`timescale 1ns/1ps
`default_nettype none
module fsw_ahb_master (
   // clock
   input  wire logic        sys_clk_i,
   // ahb-lite master side
   output logic             hsel_o,
   output logic [31:0]      haddr_o,
   output logic [1:0]       htrans_o,
   output logic             hwrite_o,
   output logic [2:0]       hsize_o,
   output logic [31:0]      hwdata_o,
   input  wire logic        hready_i,
   input  wire logic [31:0] hrdata_i
);
   initial begin
      hsel_o   = 1'b0;
      haddr_o  = 32'h0;
      htrans_o = 2'b00;
      hwrite_o = 1'b0;
      hsize_o  = 3'h2;
      hwdata_o = 32'h0;
   end

   // called just after a rising edge; returns just after the data-phase edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      hsel_o   <= 1'b1;
      haddr_o  <= {24'h0, a};
      htrans_o <= 2'b10;
      hwrite_o <= w;
      hsize_o  <= 3'h2;
      @(posedge sys_clk_i);
      while (hready_i !== 1'b1) @(posedge sys_clk_i);
      htrans_o <= 2'b00;
      hsel_o   <= 1'b0;
      // released address must not keep looking valid
      haddr_o  <= ~haddr_o;
      hwdata_o <= w ? d : ~hwdata_o;
      @(posedge sys_clk_i);
      while (hready_i !== 1'b1) @(posedge sys_clk_i);
      q = hrdata_i;
      hwdata_o <= ~hwdata_o;
   endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking bench: state machine, mailbox gate and both watchdogs
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int TICK_NS = (1 + fsw_pkg::TICK_BASE_ADD) * fsw_pkg::BASE_PERIOD_NS;
   logic        sys_clk_i;
   logic        rstn_i;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hresp;
   logic [31:0] hrdata;
   logic        mbx_req_i;
   logic        mbx_file_i;
   logic        mbx_accept_o;
   logic        mbx_reject_o;
   logic        mbx_cfg_ok_i;
   logic        pd_cfg_ok_i;
   logic        clk_cfg_ok_i;
   logic        app_access_i;
   logic [31:0] app_inputs_i;
   logic [31:0] phys_out_o;
   logic [3:0]  state_o;
   logic        pd_wd_expired_o;
   logic        app_wd_expired_o;
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;

   fsw_ahb_master m (.sys_clk_i(sys_clk_i), .hsel_o(hsel), .haddr_o(haddr),
      .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
      .hready_i(hready), .hrdata_i(hrdata));

   fsw_top dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
      .mbx_req_i(mbx_req_i), .mbx_file_i(mbx_file_i), .mbx_accept_o(mbx_accept_o),
      .mbx_reject_o(mbx_reject_o), .mbx_cfg_ok_i(mbx_cfg_ok_i), .pd_cfg_ok_i(pd_cfg_ok_i),
      .clk_cfg_ok_i(clk_cfg_ok_i), .app_access_i(app_access_i),
      .app_inputs_i(app_inputs_i), .phys_out_o(phys_out_o), .state_o(state_o),
      .pd_wd_expired_o(pd_wd_expired_o), .app_wd_expired_o(app_wd_expired_o));

   task automatic conclude();
      if (err_total == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      m.xfer(1'b1, a, d, q);
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      m.xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask

   task automatic req(input fsw_pkg::fsw_ss_t s);
      wr(fsw_pkg::ADDR_REQ, 32'(s));
   endtask

   // accept and reject are combinational, so look between edges
   task automatic mb(input logic file_req, input logic acc);
      mbx_req_i  <= 1'b1;
      mbx_file_i <= file_req;
      @(posedge sys_clk_i);
      #10;
      chk("mbx_accept", 32'(acc), 32'(mbx_accept_o));
      chk("mbx_reject", 32'(!acc), 32'(mbx_reject_o));
      @(posedge sys_clk_i);
      mbx_req_i <= 1'b0;
   endtask

   // cycles from last restart to expiry, allowing for the fractional tick
   task automatic trip(input logic app, input int cnt, input string nm);
      int n;
      n = 0;
      while ((app ? app_wd_expired_o : pd_wd_expired_o) !== 1'b1 && n < 300) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk(nm, 32'h1, 32'(n >= cnt * TICK_NS / 50 - 3 && n <= cnt * TICK_NS / 50 + 4));
   endtask

   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         conclude();
      end
   end

   initial begin
      rstn_i       = 1'b0;
      mbx_req_i    = 1'b0;
      mbx_file_i   = 1'b0;
      mbx_cfg_ok_i = 1'b0;
      pd_cfg_ok_i  = 1'b0;
      clk_cfg_ok_i = 1'b0;
      app_access_i = 1'b0;
      app_inputs_i = 32'h1234abcd;
      repeat (16) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      @(posedge sys_clk_i);
      rdchk("ctrl", fsw_pkg::ADDR_CTRL, 32'h1);
      rdchk("mult", fsw_pkg::ADDR_MULT, 32'h9c2);
      rdchk("pd_cnt", fsw_pkg::ADDR_PD_CNT, 32'h3e8);
      rdchk("app_cnt", fsw_pkg::ADDR_APP_CNT, 32'h3e8);
      rdchk("unmapped", 8'h20, 32'h0);
      chk("hresp", 32'h0, 32'(hresp));
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h01);
      mb(1'b0, 1'b0);
      req(fsw_pkg::SS_CONF);
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h11);
      mbx_cfg_ok_i <= 1'b1;
      req(fsw_pkg::SS_CONF);
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h02);
      mb(1'b0, 1'b1);
      wr(fsw_pkg::ADDR_OUT, 32'hff);
      rdchk("in_img", fsw_pkg::ADDR_IN, 32'h0);
      rdchk("out_img", fsw_pkg::ADDR_OUT, 32'h0);
      req(fsw_pkg::SS_BOOT);
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h12);
      req(fsw_pkg::SS_FULL);
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h12);
      pd_cfg_ok_i  <= 1'b1;
      clk_cfg_ok_i <= 1'b1;
      req(fsw_pkg::SS_INPUTS);
      req(fsw_pkg::SS_INPUTS);
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h04);
      rdchk("in_img", fsw_pkg::ADDR_IN, 32'h1234abcd);
      mb(1'b0, 1'b1);
      // manual watchdog settings downloaded by the master
      wr(fsw_pkg::ADDR_MULT, 32'h1);
      wr(fsw_pkg::ADDR_MULT, 32'h0);
      rdchk("mult", fsw_pkg::ADDR_MULT, 32'h1);
      wr(fsw_pkg::ADDR_PD_CNT, 32'hffff);
      rdchk("pd_cnt", fsw_pkg::ADDR_PD_CNT, 32'hffff);
      wr(fsw_pkg::ADDR_PD_CNT, 32'h4);
      wr(fsw_pkg::ADDR_OUT, 32'ha5a5a5a5);
      chk("phys_out", 32'h0, phys_out_o);
      req(fsw_pkg::SS_FULL);
      @(posedge sys_clk_i);
      chk("phys_out", 32'ha5a5a5a5, phys_out_o);
      wr(fsw_pkg::ADDR_OUT, 32'ha5a5a5a5);
      trip(1'b0, 4, "pd_trip");
      @(posedge sys_clk_i);
      chk("phys_out", 32'h0, phys_out_o);
      chk("state", 32'h8, 32'(state_o));
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h28);
      wr(fsw_pkg::ADDR_OUT, 32'h5a5a5a5a);
      @(posedge sys_clk_i);
      chk("pd_flag", 32'h0, 32'(pd_wd_expired_o));
      @(posedge sys_clk_i);
      chk("phys_out", 32'h5a5a5a5a, phys_out_o);
      wr(fsw_pkg::ADDR_APP_CNT, 32'h8);
      wr(fsw_pkg::ADDR_CTRL, 32'h3);
      app_access_i <= 1'b1;
      wr(fsw_pkg::ADDR_OUT, 32'h5a5a5a5a);
      trip(1'b0, 4, "pd_trip_app_busy");
      chk("app_flag", 32'h0, 32'(app_wd_expired_o));
      app_access_i <= 1'b0;
      trip(1'b1, 8, "app_trip");
      app_access_i <= 1'b1;
      @(posedge sys_clk_i);
      app_access_i <= 1'b0;
      @(posedge sys_clk_i);
      chk("app_flag", 32'h0, 32'(app_wd_expired_o));
      wr(fsw_pkg::ADDR_CTRL, 32'h1);
      wr(fsw_pkg::ADDR_PD_CNT, 32'h0);
      repeat (60) @(posedge sys_clk_i);
      chk("pd_flag", 32'h0, 32'(pd_wd_expired_o));
      chk("app_flag", 32'h0, 32'(app_wd_expired_o));
      chk("phys_out", 32'h5a5a5a5a, phys_out_o);
      req(fsw_pkg::SS_INIT);
      req(fsw_pkg::SS_BOOT);
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h03);
      mb(1'b1, 1'b1);
      mb(1'b0, 1'b0);
      rdchk("in_img", fsw_pkg::ADDR_IN, 32'h0);
      req(fsw_pkg::SS_CONF);
      rdchk("status", fsw_pkg::ADDR_STATUS, 32'h13);
      req(fsw_pkg::SS_INIT);
      @(posedge sys_clk_i);
      chk("state", 32'h1, 32'(state_o));
      conclude();
   end
endmodule
`default_nettype wire
